// ---- core/fmd_pkg.sv ----
// Contract
// - Ramp-select 1: rate codes step 1,2,3,4,8,12,24,48; 52.2 s to 1.1 s.
// - Smooth enable bit 7 rate-limits the remote-2 drive; at 0 no smoothing.
// - Once locked, writes to the ramp and smoothing register are ignored.
// - Read-write min-duty registers 0x64..0x66 for fans 1 to 3 reset to 0x80.
// - Min-duty 0x00 is off, 0x40 is 25, 0x80 is 50 and 0xFF is 100 percent.
// - In automatic fan control mode the min-duty registers are read-only.
// - Ramp-select 0: codes 001..110 ramp full scale in 18.8 s down to 1.6 s.
// - Auto: a fan above its start temperature runs from min duty upward.
package fmd_pkg;
   localparam int        CLK_MHZ        = 250;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_MIN1      = 8'h64;
   localparam logic [7:0] ADDR_MIN2      = 8'h65;
   localparam logic [7:0] ADDR_MIN3      = 8'h66;
   localparam logic [7:0] ADDR_ACOU2     = 8'h90;
   localparam logic [7:0] ADDR_CTRL      = 8'h91;
   localparam logic [7:0] ADDR_STAT      = 8'h92;
   localparam logic [7:0] MIN_DUTY_RST   = 8'h80;
   localparam logic [7:0] ACOU2_RST      = 8'h00;
   localparam logic [2:0] CTRL_RST       = 3'h0;
   localparam int         SMOOTH_BIT     = 7;
   localparam int         RATE_LSB       = 0;
   localparam int         CTRL_LOCK_BIT  = 0;
   localparam int         CTRL_RSEL_BIT  = 1;
   localparam int         CTRL_AUTO_BIT  = 2;
   localparam logic [7:0] DUTY_OFF       = 8'h00;
   localparam logic [7:0] DUTY_FULL      = 8'hFF;
   localparam logic [7:0] AUTO_SLOPE     = 8'h08;
   // ---------------------------------------------------------------
   // ramp timing: slot = full-scale time * step / 255
   // ---------------------------------------------------------------
   localparam longint     RAMP_SEL1_MS   = 52200;
   localparam longint     RAMP_SEL0_MS   = 18800;
   localparam longint     RAMP_SEL0_STEP = 2;
   localparam int SLOT1_CYCLES =
      int'(RAMP_SEL1_MS * 1000 * CLK_MHZ / 255);
   localparam int SLOT0_CYCLES =
      int'(RAMP_SEL0_MS * 1000 * CLK_MHZ * RAMP_SEL0_STEP / 255);

   function automatic logic [7:0] fmd_ramp_step(input logic [2:0] code);
      logic [7:0] s;
      s = 8'h01;
      case (code)
         3'h0: s = 8'h01;
         3'h1: s = 8'h02;
         3'h2: s = 8'h03;
         3'h3: s = 8'h04;
         3'h4: s = 8'h08;
         3'h5: s = 8'h0C;
         3'h6: s = 8'h18;
         default: s = 8'h30;
      endcase
      return s;
   endfunction : fmd_ramp_step
endpackage : fmd_pkg

// ---- core/fmd_pwm.sv ----
`timescale 1ns/10ps
// period of 255 counts so that code/255 is the exact duty
module fmd_pwm #(
   parameter int N = 3
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [N-1:0][7:0] duty,
   output logic      [N-1:0]      pwm
);
   import fmd_pkg::*;
   if (N < 1)
   begin : g_bad_n
      $error("fmd_pwm needs at least one channel");
   end

   logic [7:0] cnt_q;
   wire        wrap = (cnt_q == 8'hFE);

   always_ff @(posedge clk)
   begin
      if (reset || wrap)
         cnt_q <= 8'h00;
      else
         cnt_q <= cnt_q + 8'h01;
   end

   genvar g;
   for (g = 0; g < N; g++)
   begin : ch
      always_ff @(posedge clk)
      begin
         if (reset)
            pwm[g] <= 1'b0;
         else
            pwm[g] <= (cnt_q < duty[g]);
      end
   end
endmodule : fmd_pwm

// ---- core/fmd_fan_min_duty.sv ----
// Our own choice: the strobed register port.
`timescale 1ns/10ps
module fmd_fan_min_duty #(
   parameter int SLOT1_CYC = fmd_pkg::SLOT1_CYCLES,
   parameter int SLOT0_CYC = fmd_pkg::SLOT0_CYCLES
) (
   input  wire logic       CLK,
   input  wire logic       RESET,
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   input  wire logic [7:0] TEMP_REMOTE1,
   input  wire logic [7:0] TEMP_LOCAL,
   input  wire logic [7:0] TEMP_REMOTE2,
   input  wire logic [7:0] FAN_START_TEMP_1,
   input  wire logic [7:0] FAN_START_TEMP_2,
   input  wire logic [7:0] FAN_START_TEMP_3,
   output logic      [7:0] DUTY_1,
   output logic      [7:0] DUTY_2,
   output logic      [7:0] DUTY_3,
   output logic            FAN_DRIVE_1,
   output logic            FAN_DRIVE_2,
   output logic            FAN_DRIVE_3
);
   import fmd_pkg::*;

   if (SLOT1_CYC < 2 || SLOT0_CYC < 2)
   begin : g_bad_slot
      $error("slot counts must be at least 2 cycles");
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   // ---------------------------------------------------------------
   // control and acoustic registers
   // ---------------------------------------------------------------
   logic [2:0]      ctrl_q;
   logic [7:0]      acou_q;
   logic [7:0]      rdata_q;
   logic [2:0][7:0] min_q;
   logic [2:0][7:0] target;
   logic [2:0][7:0] drive_q;
   logic [2:0][7:0] temp;
   logic [2:0][7:0] start;
   logic [31:0]     slot_cnt_q;
   logic [2:0]      pwm_w;

   wire lock     = ctrl_q[CTRL_LOCK_BIT];
   wire ramp_sel = ctrl_q[CTRL_RSEL_BIT];
   wire auto_md  = ctrl_q[CTRL_AUTO_BIT];
   wire smooth   = acou_q[SMOOTH_BIT];
   wire [2:0] rate = acou_q[RATE_LSB +: 3];
   wire [7:0] step = fmd_ramp_step(rate);
   wire wr_ctrl  = WR && (ADDR == ADDR_CTRL);
   wire wr_acou  = WR && (ADDR == ADDR_ACOU2) && !lock;

   assign temp  = {TEMP_REMOTE2, TEMP_LOCAL, TEMP_REMOTE1};
   assign start = {FAN_START_TEMP_3, FAN_START_TEMP_2, FAN_START_TEMP_1};

   // lock only clears on reset, so software cannot undo it
   always_ff @(posedge CLK)
   begin
      if (RESET)
         ctrl_q <= CTRL_RST;
      else if (wr_ctrl)
         ctrl_q <= {WDATA[CTRL_AUTO_BIT], WDATA[CTRL_RSEL_BIT],
                    WDATA[CTRL_LOCK_BIT] | lock};
   end

   always_ff @(posedge CLK)
   begin
      if (RESET)
         acou_q <= ACOU2_RST;
      else if (wr_acou)
         acou_q <= {WDATA[SMOOTH_BIT], 4'h0, WDATA[RATE_LSB +: 3]};
   end

   // ---------------------------------------------------------------
   // min-duty registers and per-channel target
   // ---------------------------------------------------------------
   genvar g;
   for (g = 0; g < 3; g++)
   begin : ch
      wire        hit   = WR && (ADDR == ADDR_MIN1 + 8'(g)) && !auto_md;
      wire        above = temp[g] > start[g];
      wire [7:0]  diff  = temp[g] - start[g];
      wire [15:0] boost = 16'(diff) * 16'(AUTO_SLOPE);
      wire [15:0] sum   = 16'(min_q[g]) + boost;
      wire [7:0]  ramp  = (sum > 16'(DUTY_FULL)) ? DUTY_FULL : sum[7:0];

      always_ff @(posedge CLK)
      begin
         if (RESET)
            min_q[g] <= MIN_DUTY_RST;
         else if (hit)
            min_q[g] <= WDATA;
      end

      // manual mode holds the fan at its programmed min duty
      assign target[g] = !auto_md ? min_q[g] :
                         above    ? ramp     : DUTY_OFF;
   end

   // ---------------------------------------------------------------
   // ramp slot divider, remote-2 channel only
   // ---------------------------------------------------------------
   localparam int SLOT_MAX = (SLOT1_CYC > SLOT0_CYC) ? SLOT1_CYC : SLOT0_CYC;

   wire [31:0] slot_lim = ramp_sel ? 32'(SLOT1_CYC - 1)
                                   : 32'(SLOT0_CYC - 1);
   wire        slot_tick = (slot_cnt_q >= slot_lim);

   always_ff @(posedge CLK)
   begin
      if (RESET || slot_tick)
         slot_cnt_q <= 32'h0;
      else
         slot_cnt_q <= slot_cnt_q + 32'h1;
   end

   wire [8:0] up_sum  = 9'(drive_q[2]) + 9'(step);
   wire [8:0] dn_dif  = 9'(drive_q[2]) - 9'(step);
   wire       go_up   = target[2] > drive_q[2];
   wire       go_dn   = target[2] < drive_q[2];
   wire [7:0] up_val  = (up_sum > 9'(target[2])) ? target[2] : up_sum[7:0];
   wire [7:0] dn_val  = (dn_dif[8] || dn_dif[7:0] < target[2])
                        ? target[2] : dn_dif[7:0];
   // limited step per slot keeps fan speed changes slow to the ear
   wire [7:0] smooth_d = !slot_tick ? drive_q[2] :
                         go_up      ? up_val     :
                         go_dn      ? dn_val     : drive_q[2];
   wire [7:0] drive3_d = smooth ? smooth_d : target[2];

   always_ff @(posedge CLK)
   begin
      if (RESET)
         drive_q <= {3{MIN_DUTY_RST}};
      else
         drive_q <= {drive3_d, target[1], target[0]};
   end

   assign DUTY_1 = drive_q[0];
   assign DUTY_2 = drive_q[1];
   assign DUTY_3 = drive_q[2];

   fmd_pwm #(
      .N     (3)
   ) u_pwm (
      .clk   (CLK),
      .reset (RESET),
      .duty  (drive_q),
      .pwm   (pwm_w)
   );

   assign FAN_DRIVE_1 = pwm_w[0];
   assign FAN_DRIVE_2 = pwm_w[1];
   assign FAN_DRIVE_3 = pwm_w[2];

   // ---------------------------------------------------------------
   // register read port
   // ---------------------------------------------------------------
   logic [7:0] rd_mux;
   always_comb
   begin
      if (ADDR == ADDR_MIN1)
         rd_mux = min_q[0];
      else if (ADDR == ADDR_MIN2)
         rd_mux = min_q[1];
      else if (ADDR == ADDR_MIN3)
         rd_mux = min_q[2];
      else if (ADDR == ADDR_ACOU2)
         rd_mux = acou_q;
      else if (ADDR == ADDR_CTRL)
         rd_mux = {5'h00, ctrl_q};
      else if (ADDR == ADDR_STAT)
         rd_mux = drive_q[2];
      else
         rd_mux = 8'h00;
   end

   // data valid only in the cycle after the read strobe
   always_ff @(posedge CLK)
   begin
      if (RESET || !RD)
         rdata_q <= 8'h00;
      else
         rdata_q <= rd_mux;
   end
   assign RDATA = rdata_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_wr_min1;
      WR && ADDR == ADDR_MIN1 && !auto_md;
   endsequence

   min_reset_a: assert property (@(posedge CLK) disable iff (1'b0)
      RESET |=> min_q == {3{MIN_DUTY_RST}})
      else $error("min duty not at reset value");
   min_write_a: assert property (
      s_wr_min1 |=> min_q[0] == $past(WDATA))
      else $error("min duty write lost");
   auto_ro_a: assert property (
      auto_md && WR && ADDR == ADDR_MIN2 |=> $stable(min_q[1]))
      else $error("min duty changed in auto mode");
   acou_lock_a: assert property (
      lock && WR && ADDR == ADDR_ACOU2 |=> $stable(acou_q))
      else $error("locked acoustic register written");
   read_back_a: assert property (
      RD && ADDR == ADDR_MIN2 |=> RDATA == $past(min_q[1]))
      else $error("min duty read back wrong");
   no_smooth_a: assert property (
      !smooth ##1 !smooth |-> drive_q[2] == $past(target[2]))
      else $error("remote-2 drive not direct without smoothing");
   step_limit_a: assert property (
      smooth ##1 smooth && go_up |=>
      9'(drive_q[2]) <= 9'($past(drive_q[2])) + 9'($past(step)))
      else $error("smoothed step too large");
   auto_floor_a: assert property (
      auto_md && temp[0] > start[0] |-> target[0] >= min_q[0])
      else $error("auto drive below min duty");
   full_on_a: assert property (
      (drive_q[0] == DUTY_FULL) [*3] |-> FAN_DRIVE_1)
      else $error("full duty not held high");
   slot_bound_a: assert property (
      slot_cnt_q <= 32'(SLOT_MAX - 1))
      else $error("slot counter overran");
endmodule : fmd_fan_min_duty

// ---- sim/fmd_host_model.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// host side of the register port
// ---------------------------------------------------------------
module fmd_host_model (
   input  wire logic       clk,
   output logic      [7:0] addr,
   output logic      [7:0] wdata,
   output logic            wr,
   output logic            rd,
   input  wire logic [7:0] rdata
);
   initial
   begin
      addr  = 8'h00;
      wdata = 8'h00;
      wr    = 1'b0;
      rd    = 1'b0;
   end

   // strobe dropped at the next edge, so a repeat call leaves one idle cycle
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : bus_wr

   // data stands only in the cycle after the strobe
   task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : bus_rd
endmodule : fmd_host_model

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
module testbench;
   import fmd_pkg::*;
   logic       CLK   = 1'b0;
   logic       RESET = 1'b1;
   logic [7:0] ADDR;
   logic [7:0] WDATA;
   logic       WR;
   logic       RD;
   logic [7:0] RDATA;
   logic [7:0] TR1 = 8'h00;
   logic [7:0] TL  = 8'h00;
   logic [7:0] TR2 = 8'h00;
   logic [7:0] TS1 = 8'h32;
   logic [7:0] DUTY_1;
   logic [7:0] DUTY_2;
   logic [7:0] DUTY_3;
   logic       FAN_DRIVE_1;
   logic       FAN_DRIVE_2;
   logic       FAN_DRIVE_3;
   logic [7:0] vals [3] = '{DUTY_OFF, 8'h40, DUTY_FULL};
   int         failures = 0;
   int         checks   = 0;
   int         cycles   = 0;
   int         hi       = 0;
   int         gap      = 0;
   logic [7:0] dlt;

   always #2 CLK = ~CLK;

   fmd_host_model i_host (.clk(CLK), .addr(ADDR), .wdata(WDATA), .wr(WR),
      .rd(RD), .rdata(RDATA));

   // short slots keep the smoothing ramp within a few hundred cycles
   fmd_fan_min_duty #(.SLOT1_CYC(16), .SLOT0_CYC(12)) i_dut (
      .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .TEMP_REMOTE1(TR1), .TEMP_LOCAL(TL),
      .TEMP_REMOTE2(TR2), .FAN_START_TEMP_1(TS1),
      .FAN_START_TEMP_2(8'h32), .FAN_START_TEMP_3(8'h32),
      .DUTY_1(DUTY_1), .DUTY_2(DUTY_2), .DUTY_3(DUTY_3),
      .FAN_DRIVE_1(FAN_DRIVE_1), .FAN_DRIVE_2(FAN_DRIVE_2),
      .FAN_DRIVE_3(FAN_DRIVE_3));

   // ---------------------------------------------------------------
   // checking
   // ---------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      i_host.bus_rd(a, v);
      chk(v, exp);
   endtask : rdchk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask : wait_cyc

   // cycles to the next change of fan 3 duty, and the signed step taken
   task automatic tick_gap(output int n, output logic [7:0] d);
      logic [7:0] v;
      v = DUTY_3;
      n = 0;
      while (DUTY_3 === v && n < 100)
      begin
         @(posedge CLK);
         #1;
         n++;
      end
      d = DUTY_3 - v;
   endtask : tick_gap

   always @(posedge CLK)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         $display("unexpected at %0t: timeout", $time);
         print_verdict();
      end
   end

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge CLK);
      RESET <= 1'b0;
      wait_cyc(2);
      for (int i = 0; i < 3; i++)
         rdchk(ADDR_MIN1 + 8'(i), MIN_DUTY_RST);
      chk(DUTY_1, MIN_DUTY_RST);
      foreach (vals[k])
         for (int i = 0; i < 3; i++)
         begin
            i_host.bus_wr(ADDR_MIN1 + 8'(i), vals[k]);
            rdchk(ADDR_MIN1 + 8'(i), vals[k]);
         end
      i_host.bus_wr(ADDR_MIN1, 8'h40);
      wait_cyc(4);
      chk(DUTY_1, 8'h40);
      repeat (255)
      begin
         @(posedge CLK);
         hi += int'(FAN_DRIVE_1 === 1'b1);
      end
      chk(8'(hi), 8'h40);
      rdchk(8'h00, 8'h00);
      i_host.bus_wr(ADDR_ACOU2, 8'hFF);
      rdchk(ADDR_ACOU2, 8'h87);
      i_host.bus_wr(ADDR_ACOU2, 8'h07);
      i_host.bus_wr(ADDR_CTRL, 8'h06);
      i_host.bus_wr(ADDR_MIN1, 8'h11);
      rdchk(ADDR_MIN1, 8'h40);
      i_host.bus_wr(ADDR_MIN2, 8'h11);
      rdchk(ADDR_MIN2, DUTY_FULL);
      @(posedge CLK);
      TR1 <= 8'h34;
      wait_cyc(3);
      chk(DUTY_1, 8'h50);
      chk(DUTY_2, DUTY_OFF);
      @(posedge CLK);
      TS1 <= 8'h30;
      wait_cyc(3);
      chk(DUTY_1, 8'h60);
      @(posedge CLK);
      TR2 <= 8'h64;
      wait_cyc(3);
      chk(DUTY_3, DUTY_FULL);
      @(posedge CLK);
      TR2 <= 8'h00;
      wait_cyc(3);
      chk(DUTY_3, DUTY_OFF);
      i_host.bus_wr(ADDR_ACOU2, 8'h87);
      @(posedge CLK);
      TR2 <= 8'h64;
      wait_cyc(3);
      chk({7'h00, DUTY_3 <= 8'h30}, 8'h01);
      tick_gap(gap, dlt);
      tick_gap(gap, dlt);
      chk(8'(gap), 8'h10);
      chk(dlt, 8'h30);
      wait_cyc(200);
      chk(DUTY_3, DUTY_FULL);
      rdchk(ADDR_STAT, DUTY_FULL);
      i_host.bus_wr(ADDR_CTRL, 8'h04);
      i_host.bus_wr(ADDR_ACOU2, 8'h84);
      @(posedge CLK);
      TR2 <= 8'h00;
      tick_gap(gap, dlt);
      tick_gap(gap, dlt);
      chk(8'(gap), 8'h0C);
      chk(dlt, 8'hF8);
      i_host.bus_wr(ADDR_ACOU2, 8'h87);
      i_host.bus_wr(ADDR_CTRL, 8'h07);
      i_host.bus_wr(ADDR_ACOU2, 8'h00);
      rdchk(ADDR_ACOU2, 8'h87);
      @(posedge CLK);
      RESET <= 1'b1;
      wait_cyc(2);
      @(posedge CLK);
      RESET <= 1'b0;
      wait_cyc(2);
      chk(DUTY_3, MIN_DUTY_RST);
      rdchk(ADDR_MIN2, MIN_DUTY_RST);
      print_verdict();
   end
endmodule : testbench
